// *** switchgear_position_supervisor_tb.sv ***
// Purpose: register-level bench of the position supervisor
// Assumes: gear models travel in 7 cycles, tick of 2 clocks
// Notes:   unit 0 element, unit 1 truck
`timescale 1ns/1ns

module switchgear_position_supervisor_tb
   import swp_pkg::*;
;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [ADDR_W-1:0] addr = 8'h00;
   logic [DATA_W-1:0] wr_data = 32'h0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic plug_removed_pin = 1'b0;
   logic [UNITS-1:0] stuck = 2'h0;
   logic [DATA_W-1:0] rd_data;
   logic [UNITS-1:0] aux_closed, aux_open, close_drive, open_drive;
   logic [POS_STRIDE*UNITS-1:0] pos_code;
   logic plug_removed, irq;
   int bad_count = 0;
   int checks_done = 0;

   initial forever #5 clock = ~clock;

   swp_top #(.TICK_CYCLES(2)) u_swp_top (.clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .aux_closed(aux_closed), .aux_open(aux_open),
      .plug_removed_pin(plug_removed_pin), .close_drive(close_drive), .open_drive(open_drive),
      .pos_code(pos_code), .plug_removed(plug_removed), .irq(irq));
   swp_gear #(.TRAVEL(6)) u_swp_gear [UNITS-1:0] (.clock(clock), .rst(rst), .close_drive(close_drive),
      .open_drive(open_drive), .stuck(stuck), .aux_closed(aux_closed), .aux_open(aux_open));

   // ----------------------------------------
   // bus cycles and checks
   // ----------------------------------------
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      #1 chk("rd_data", rd_data, exp);
   endtask
   task automatic wait_pos(input int u, input logic [1:0] c);
      for (int i = 0; i < 80; i++) begin
         @(posedge clock);
         #1;
         if (pos_code[POS_STRIDE*u +: 2] === c) return;
      end
      bad_count++;
      $display("[ERR] pos_code expected %h seen %h", c, pos_code);
      give_verdict();
   endtask
   // command, coil on, transit, end position, coil off
   task automatic go(input int u, input int c, input logic [1:0] tgt);
      wr(REG_COMMAND, 32'h1 << (CMD_STRIDE * u + c));
      repeat (2) @(posedge clock);
      #1 chk("coils", {close_drive[u], open_drive[u]}, (c == CMD_CLOSE) ? 32'h2 : 32'h1);
      chk("transit", pos_code[POS_STRIDE*u +: 2], POS_TRANSIT);
      wait_pos(u, tgt);
      @(posedge clock);
      #1 chk("coils off", {close_drive[u], open_drive[u]}, 32'h0);
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      repeat (8) @(posedge clock);
      rd(REG_STATUS, 32'h5);
      rd(8'h80, 32'h0);
      for (int i = 0; i < 4; i++) wr(REG_TIME_BASE + 8'(4 * i), 32'(8 + i));
      rd(8'h4c, 32'hb);
      wr(REG_IRQ_ENABLE, 32'h3f);
      go(1, CMD_CLOSE, POS_CLOSED);
      repeat (2) @(posedge clock);
      #1 chk("irq", irq, 1'b1);
      rd(REG_IRQ_STATUS, 32'h8);
      go(0, CMD_CLOSE, POS_CLOSED);
      wr(REG_IRQ_ENABLE, 32'h1f);
      wr(REG_IRQ_CLEAR, 32'h3f);
      wr(REG_COMMAND, 32'h8);
      repeat (3) @(posedge clock);
      #1 chk("masked irq", irq, 1'b0);
      chk("truck held", open_drive[1], 1'b0);
      rd(REG_IRQ_STATUS, 32'h20);
      rd(REG_STATUS, 32'ha);
      go(0, CMD_OPEN, POS_OPEN);
      go(1, CMD_OPEN, POS_OPEN);
      wr(REG_IRQ_CLEAR, 32'h3f);
      @(posedge clock);
      stuck <= 2'h1;
      go(0, CMD_CLOSE, POS_FAULT);
      rd(REG_IRQ_STATUS, 32'h2);
      wr(REG_WIRING, 32'hd);
      go(0, CMD_CLOSE, POS_FAULT);
      wr(REG_WIRING, 32'hf);
      @(posedge clock);
      stuck <= 2'h0;
      go(0, CMD_CLOSE, POS_CLOSED);
      wr(REG_IRQ_CLEAR, 32'h3f);
      plug_removed_pin <= 1'b1;
      repeat (8) @(posedge clock);
      #1 chk("removed", plug_removed, 1'b1);
      chk("forced open", pos_code[1:0], POS_OPEN);
      rd(REG_STATUS, 32'h105);
      wr(REG_OVERRIDE, 32'h5);
      rd(REG_IRQ_STATUS, 32'h4);
      @(posedge clock);
      plug_removed_pin <= 1'b0;
      repeat (8) @(posedge clock);
      #1 chk("element back", pos_code[1:0], POS_CLOSED);
      give_verdict();
   end
endmodule

// *** swp_chk.sv ***
// Purpose: port-level checks of the position supervisor
// Assumes: both contacts wired, no override on unit 1
// Notes:   bound into swp_top after the module
`timescale 1ns/1ns

module swp_chk
   import swp_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [UNITS-1:0] aux_closed,
   input wire logic [UNITS-1:0] aux_open,
   input wire logic plug_removed_pin,
   input wire logic [UNITS-1:0] close_drive,
   input wire logic [UNITS-1:0] open_drive,
   input wire logic [POS_STRIDE*UNITS-1:0] pos_code,
   input wire logic plug_removed
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // coils, position and plug relations
   AST_DRV_EXCL: assert property ((close_drive & open_drive) == 2'h0)
      else $error("close and open coil on together");
   AST_CLOSE_END: assert property (close_drive[0] && pos_code[1:0] == POS_CLOSED |=> !close_drive[0])
      else $error("close coil held at closed position");
   AST_OPEN_END: assert property (open_drive[1] && pos_code[3:2] == POS_OPEN |=> !open_drive[1])
      else $error("open coil held at open position");
   AST_NO_FAULT_DRV: assert property ((close_drive[0] || open_drive[0]) |-> pos_code[1:0] != POS_FAULT)
      else $error("fault shown while timer runs");
   AST_PLUG_SET: assert property (plug_removed_pin [*4] |=> plug_removed)
      else $error("removed status missing");
   AST_PLUG_CLR: assert property (!plug_removed_pin [*4] |=> !plug_removed)
      else $error("removed status stuck");
   AST_PLUG_FORCE: assert property (plug_removed [*3] |-> pos_code[1:0] == POS_OPEN)
      else $error("removed element not open");
   AST_POS_CLOSED: assert property (
      (aux_closed[1] && !aux_open[1] && !close_drive[1] && !open_drive[1]) [*6] |-> pos_code[3:2] == POS_CLOSED)
      else $error("contacts closed, code not closed");
   AST_POS_OPEN: assert property (
      (!aux_closed[1] && aux_open[1] && !close_drive[1] && !open_drive[1]) [*6] |-> pos_code[3:2] == POS_OPEN)
      else $error("contacts open, code not open");
endmodule

bind swp_top swp_chk u_swp_chk (.clock(clock), .rst(rst), .aux_closed(aux_closed), .aux_open(aux_open),
   .plug_removed_pin(plug_removed_pin), .close_drive(close_drive), .open_drive(open_drive),
   .pos_code(pos_code), .plug_removed(plug_removed));

// *** swp_gear.sv ***
// Purpose: one switchgear answering its coils with aux contacts
// Assumes: coils high while energised
// Notes:   stuck jams the gear mid travel, contacts 00
`timescale 1ns/1ns

module swp_gear #(
   parameter int TRAVEL = 6
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic close_drive,
   input wire logic open_drive,
   input wire logic stuck,
   output logic aux_closed,
   output logic aux_open
);
   logic is_closed;
   logic moving;
   int cnt;
   assign moving = (close_drive && !is_closed) || (open_drive && is_closed);
   // travel time counter
   always_ff @(posedge clock) begin
      if (rst || !moving || stuck) cnt <= 0;
      else cnt <= cnt + 1;
   end
   // end position flips after travel
   always_ff @(posedge clock) begin
      if (rst) is_closed <= 1'b0;
      else if (moving && cnt == TRAVEL) is_closed <= !is_closed;
   end
   assign aux_closed = is_closed && !moving && !stuck;
   assign aux_open = !is_closed && !moving && !stuck;
endmodule

// *** swp_top.sv ***
// Purpose: switchgear position supervisor top, register port, pin sync,
//          prescaler, withdrawable-gear glue and interrupt
// Assumes: contact and plug pins are asynchronous to clock
// Notes:   unit 0 is the switching element, unit 1 the truck or earthing part
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns

module swp_top
   import swp_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [DATA_W-1:0] rd_data,
   input wire logic [UNITS-1:0] aux_closed,
   input wire logic [UNITS-1:0] aux_open,
   input wire logic plug_removed_pin,
   output logic [UNITS-1:0] close_drive,
   output logic [UNITS-1:0] open_drive,
   output logic [POS_STRIDE*UNITS-1:0] pos_code,
   output logic plug_removed,
   output logic irq
);
   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   localparam logic [PRE_W-1:0] PRESCALE_RST = PRE_W'(TICK_CYCLES);

   logic [UNITS-1:0] aux_closed_s1;
   logic [UNITS-1:0] aux_closed_s2;
   logic [UNITS-1:0] aux_open_s1;
   logic [UNITS-1:0] aux_open_s2;
   logic removed_s1;
   logic removed_s2;

   logic interlock_en;
   logic [PRE_W-1:0] prescale;
   logic [PRE_W-1:0] pre_cnt;
   logic tick;
   logic [WIRE_STRIDE*UNITS-1:0] wiring;
   logic [TIME_W-1:0] close_time [UNITS];
   logic [TIME_W-1:0] open_time [UNITS];
   logic [UNITS-1:0] ovr_en;
   logic [1:0] ovr_code [UNITS];

   logic [EV_W-1:0] irq_status;
   logic [EV_W-1:0] irq_enable;
   logic [EV_W-1:0] events;
   logic [EV_W-1:0] clear_mask;

   logic wr_cmd;
   logic wr_ovr;
   logic [UNITS-1:0] req_close;
   logic [UNITS-1:0] req_open;
   logic [UNITS-1:0] cmd_close;
   logic [UNITS-1:0] cmd_open;
   logic [UNITS-1:0] cmd_reject;
   logic [UNITS-1:0] ovr_reject;
   logic [UNITS-1:0] force_open;
   logic [UNITS-1:0] unit_close;
   logic [UNITS-1:0] unit_open;
   logic [UNITS-1:0] unit_done;
   logic [UNITS-1:0] unit_fault;
   logic [1:0] unit_pos [UNITS];
   logic [1:0] next_code [UNITS];
   logic element_closed;
   logic [DATA_W-1:0] next_rd_data;

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------

   // two flops on every contact and plug pin
   always_ff @(posedge clock) begin
      if (rst) begin
         aux_closed_s1 <= '0;
         aux_closed_s2 <= '0;
         aux_open_s1 <= '0;
         aux_open_s2 <= '0;
         removed_s1 <= 1'b0;
         removed_s2 <= 1'b0;
      end else begin
         aux_closed_s1 <= aux_closed;
         aux_closed_s2 <= aux_closed_s1;
         aux_open_s1 <= aux_open;
         aux_open_s2 <= aux_open_s1;
         removed_s1 <= plug_removed_pin;
         removed_s2 <= removed_s1;
      end
   end

   // ---------------------------------------------------------------
   // travel time prescaler
   // ---------------------------------------------------------------

   always_ff @(posedge clock) begin
      if (rst) begin
         pre_cnt <= '0;
         tick <= 1'b0;
      end else if (pre_cnt == '0) begin
         pre_cnt <= (prescale == '0) ? '0 : prescale - 1'b1;
         tick <= 1'b1;
      end else begin
         pre_cnt <= pre_cnt - 1'b1;
         tick <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // configuration registers
   // ---------------------------------------------------------------

   // global config, prescale and wiring
   always_ff @(posedge clock) begin
      if (rst) begin
         interlock_en <= CONFIG_RST;
         prescale <= PRESCALE_RST;
         wiring <= WIRING_RST;
      end else if (wr_en) begin
         if (addr == REG_CONFIG) begin
            interlock_en <= wr_data[CFG_INTERLOCK];
         end
         if (addr == REG_PRESCALE) begin
            prescale <= wr_data[PRE_W-1:0];
         end
         if (addr == REG_WIRING) begin
            // at least one contact should be set
            wiring <= wr_data[WIRE_STRIDE*UNITS-1:0];
         end
      end
   end

   // separate close and open times per unit
   always_ff @(posedge clock) begin
      if (rst) begin
         for (int i = 0; i < UNITS; i++) begin
            close_time[i] <= TIME_RST;
            open_time[i] <= TIME_RST;
         end
      end else if (wr_en) begin
         for (int i = 0; i < UNITS; i++) begin
            if (addr == ADDR_W'(REG_TIME_BASE + TIME_STRIDE * i)) begin
               close_time[i] <= wr_data[TIME_W-1:0];
            end
            if (addr == ADDR_W'(REG_TIME_BASE + TIME_STRIDE * i + OPEN_TIME_OFS)) begin
               open_time[i] <= wr_data[TIME_W-1:0];
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // commands, interlock and override
   // ---------------------------------------------------------------
   assign wr_cmd = wr_en && (addr == REG_COMMAND);
   assign wr_ovr = wr_en && (addr == REG_OVERRIDE);
   assign element_closed = (pos_code[POS_STRIDE*ELEMENT +: POS_STRIDE] == POS_CLOSED);

   generate
      for (genvar g = 0; g < UNITS; g++) begin : g_unit
         assign req_close[g] = wr_cmd & wr_data[CMD_STRIDE*g + CMD_CLOSE];
         assign req_open[g] = wr_cmd & wr_data[CMD_STRIDE*g + CMD_OPEN];
         if (g == TRUCK) begin : g_truck
            assign cmd_reject[g] = (req_close[g] & req_open[g]) |
                                   (req_open[g] & interlock_en & element_closed);
            // no plug input on this unit
            assign force_open[g] = 1'b0;
            assign ovr_reject[g] = 1'b0;
         end else if (g == ELEMENT) begin : g_element
            // element stays switchable in both truck positions
            assign cmd_reject[g] = req_close[g] & req_open[g];
            assign force_open[g] = removed_s2;
            assign ovr_reject[g] = wr_ovr & removed_s2;
         end else begin : g_other
            assign cmd_reject[g] = req_close[g] & req_open[g];
            assign force_open[g] = 1'b0;
            assign ovr_reject[g] = 1'b0;
         end
         assign cmd_close[g] = req_close[g] & ~cmd_reject[g];
         assign cmd_open[g] = req_open[g] & ~cmd_reject[g];

         // element and truck as separate units
         swp_unit u_unit (
            .clock(clock),
            .rst(rst),
            .tick(tick),
            .cmd_close(cmd_close[g]),
            .cmd_open(cmd_open[g]),
            .close_time(close_time[g]),
            .open_time(open_time[g]),
            .wired_closed(wiring[WIRE_STRIDE*g + WIRE_CLOSED]),
            .wired_open(wiring[WIRE_STRIDE*g + WIRE_OPEN]),
            .aux_closed(aux_closed_s2[g]),
            .aux_open(aux_open_s2[g]),
            .force_open(force_open[g]),
            .close_drive(unit_close[g]),
            .open_drive(unit_open[g]),
            .pos(unit_pos[g]),
            .ev_done(unit_done[g]),
            .ev_fault(unit_fault[g])
         );

         // event vector for this unit
         assign events[EV_STRIDE*g + EV_DONE] = unit_done[g];
         assign events[EV_STRIDE*g + EV_FAULT] = unit_fault[g];
         assign events[EV_STRIDE*g + EV_REJECT] = cmd_reject[g] | ovr_reject[g];

         assign next_code[g] = force_open[g] ? POS_OPEN :
                               (ovr_en[g] ? ovr_code[g] : unit_pos[g]);
      end
   endgenerate

   // override store, refused writes leave it unchanged
   always_ff @(posedge clock) begin
      if (rst) begin
         ovr_en <= '0;
         for (int i = 0; i < UNITS; i++) begin
            ovr_code[i] <= POS_TRANSIT;
         end
      end else if (wr_ovr) begin
         for (int i = 0; i < UNITS; i++) begin
            if (!ovr_reject[i]) begin
               ovr_en[i] <= wr_data[OVR_STRIDE*i + OVR_EN];
               ovr_code[i] <= wr_data[OVR_STRIDE*i + OVR_CODE +: 2];
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // pin and position outputs
   // ---------------------------------------------------------------

   always_ff @(posedge clock) begin
      if (rst) begin
         pos_code <= {UNITS{POS_FAULT}};
      end else begin
         for (int i = 0; i < UNITS; i++) begin
            pos_code[POS_STRIDE*i +: POS_STRIDE] <= next_code[i];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         plug_removed <= 1'b0;
      end else begin
         plug_removed <= removed_s2;
      end
   end

   // coil drives, retimed to the pins
   always_ff @(posedge clock) begin
      if (rst) begin
         close_drive <= '0;
         open_drive <= '0;
      end else begin
         close_drive <= unit_close;
         open_drive <= unit_open;
      end
   end

   // ---------------------------------------------------------------
   // interrupts
   // ---------------------------------------------------------------
   assign clear_mask = (wr_en && addr == REG_IRQ_CLEAR) ? wr_data[EV_W-1:0] : '0;

   // sticky status, a new event beats the clear
   always_ff @(posedge clock) begin
      if (rst) begin
         irq_status <= '0;
      end else begin
         irq_status <= (irq_status & ~clear_mask) | events;
      end
   end

   // enable mask
   always_ff @(posedge clock) begin
      if (rst) begin
         irq_enable <= '0;
      end else if (wr_en && addr == REG_IRQ_ENABLE) begin
         irq_enable <= wr_data[EV_W-1:0];
      end
   end

   // level interrupt from enabled status
   always_ff @(posedge clock) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_enable);
      end
   end

   // ---------------------------------------------------------------
   // read port
   // ---------------------------------------------------------------

   // read mux, unmapped and write-only read zero
   always_comb begin
      next_rd_data = '0;
      case (addr)
         REG_CONFIG: begin
            next_rd_data[CFG_INTERLOCK] = interlock_en;
         end
         REG_PRESCALE: begin
            next_rd_data[PRE_W-1:0] = prescale;
         end
         REG_WIRING: begin
            next_rd_data[WIRE_STRIDE*UNITS-1:0] = wiring;
         end
         REG_OVERRIDE: begin
            for (int i = 0; i < UNITS; i++) begin
               next_rd_data[OVR_STRIDE*i + OVR_EN] = ovr_en[i];
               next_rd_data[OVR_STRIDE*i + OVR_CODE +: 2] = ovr_code[i];
            end
         end
         REG_STATUS: begin
            next_rd_data[POS_STRIDE*UNITS-1:0] = pos_code;
            next_rd_data[STAT_REMOVED] = plug_removed;
            for (int i = 0; i < UNITS; i++) begin
               next_rd_data[STAT_DRIVE + 2*i] = close_drive[i];
               next_rd_data[STAT_DRIVE + 2*i + 1] = open_drive[i];
            end
         end
         REG_IRQ_STATUS: begin
            next_rd_data[EV_W-1:0] = irq_status;
         end
         REG_IRQ_ENABLE: begin
            next_rd_data[EV_W-1:0] = irq_enable;
         end
         default: begin
            for (int i = 0; i < UNITS; i++) begin
               if (addr == ADDR_W'(REG_TIME_BASE + TIME_STRIDE * i)) begin
                  next_rd_data[TIME_W-1:0] = close_time[i];
               end
               if (addr == ADDR_W'(REG_TIME_BASE + TIME_STRIDE * i + OPEN_TIME_OFS)) begin
                  next_rd_data[TIME_W-1:0] = open_time[i];
               end
            end
         end
      endcase
   end

   // data stands only in the cycle after the strobe
   always_ff @(posedge clock) begin
      if (rst) begin
         rd_data <= '0;
      end else if (rd_en) begin
         rd_data <= next_rd_data;
      end else begin
         rd_data <= '0;
      end
   end
endmodule

// *** swp_unit.sv ***
// Purpose: constants for the switchgear position supervisor, and the
//          per-switchgear travel supervisor that the top instantiates
// Assumes: one clock, synchronous active-high reset, contacts already
//          synchronised by the top
// Notes:   unit 0 is the switching element, unit 1 the movable truck
`timescale 1ns/1ns

package swp_pkg;
   // ---------------------------------------------------------------
   // unit layout
   // ---------------------------------------------------------------
   localparam int UNITS = 2;
   localparam int ELEMENT = 0;
   localparam int TRUCK = 1;
   localparam int TIME_W = 16;
   localparam int PRE_W = 20;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // position codes
   localparam logic [1:0] POS_TRANSIT = 2'h0;
   localparam logic [1:0] POS_OPEN = 2'h1;
   localparam logic [1:0] POS_CLOSED = 2'h2;
   localparam logic [1:0] POS_FAULT = 2'h3;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] REG_CONFIG = 8'h00;
   localparam logic [ADDR_W-1:0] REG_PRESCALE = 8'h04;
   localparam logic [ADDR_W-1:0] REG_WIRING = 8'h08;
   localparam logic [ADDR_W-1:0] REG_COMMAND = 8'h0c;
   localparam logic [ADDR_W-1:0] REG_OVERRIDE = 8'h10;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h14;
   localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h18;
   localparam logic [ADDR_W-1:0] REG_IRQ_CLEAR = 8'h1c;
   localparam logic [ADDR_W-1:0] REG_IRQ_ENABLE = 8'h20;
   localparam logic [ADDR_W-1:0] REG_TIME_BASE = 8'h40;
   localparam logic [ADDR_W-1:0] TIME_STRIDE = 8'h08;
   localparam logic [ADDR_W-1:0] OPEN_TIME_OFS = 8'h04;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CFG_INTERLOCK = 0;
   localparam int WIRE_CLOSED = 0;
   localparam int WIRE_OPEN = 1;
   localparam int WIRE_STRIDE = 2;
   localparam int CMD_CLOSE = 0;
   localparam int CMD_OPEN = 1;
   localparam int CMD_STRIDE = 2;
   localparam int OVR_EN = 0;
   localparam int OVR_CODE = 1;
   localparam int OVR_STRIDE = 4;
   localparam int POS_STRIDE = 2;
   localparam int STAT_REMOVED = 8;
   localparam int STAT_DRIVE = 16;
   localparam int EV_DONE = 0;
   localparam int EV_FAULT = 1;
   localparam int EV_REJECT = 2;
   localparam int EV_STRIDE = 3;
   localparam int EV_W = EV_STRIDE * UNITS;

   // ---------------------------------------------------------------
   // reset values and timing
   // ---------------------------------------------------------------
   localparam logic CONFIG_RST = 1'h1;
   localparam logic [WIRE_STRIDE*UNITS-1:0] WIRING_RST = 4'hf;
   localparam logic [TIME_W-1:0] TIME_RST = 16'h00c8;
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_NS = 1000000;
   localparam int TICK_CYCLES_DEF = TICK_NS / CLK_PERIOD_NS;
endpackage

// one switchgear: travel timer, drive outputs, validated position
module swp_unit
   import swp_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic tick,
   input wire logic cmd_close,
   input wire logic cmd_open,
   input wire logic [TIME_W-1:0] close_time,
   input wire logic [TIME_W-1:0] open_time,
   input wire logic wired_closed,
   input wire logic wired_open,
   input wire logic aux_closed,
   input wire logic aux_open,
   input wire logic force_open,
   output logic close_drive,
   output logic open_drive,
   output logic [1:0] pos,
   output logic ev_done,
   output logic ev_fault
);
   logic running;
   logic dir_close;
   logic failed;
   logic [TIME_W-1:0] cnt;
   logic eff_closed;
   logic eff_open;
   logic at_closed;
   logic at_open;
   logic target_hit;
   logic single;
   logic no_contact;
   logic new_cmd;
   logic expire;
   logic [1:0] next_pos;

   // missing contact derived from the other
   assign eff_closed = wired_closed ? aux_closed : ~aux_open;
   assign eff_open = wired_open ? aux_open : ~aux_closed;
   assign single = wired_closed ^ wired_open;
   assign no_contact = ~wired_closed & ~wired_open;
   assign at_closed = eff_closed & ~eff_open;
   assign at_open = eff_open & ~eff_closed;
   assign target_hit = dir_close ? at_closed : at_open;
   assign new_cmd = cmd_close | cmd_open;
   assign expire = running & ~new_cmd & ~target_hit & (cnt == '0);

   always_ff @(posedge clock) begin
      if (rst) begin
         running <= 1'b0;
         dir_close <= 1'b0;
         cnt <= '0;
      end else if (new_cmd) begin
         running <= 1'b1;
         dir_close <= cmd_close;
         cnt <= cmd_close ? close_time : open_time;
      end else if (running) begin
         // target position feedback or timeout ends travel
         if (target_hit || cnt == '0) begin
            running <= 1'b0;
         end else if (tick) begin
            cnt <= cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         close_drive <= 1'b0;
         open_drive <= 1'b0;
      end else if (new_cmd) begin
         close_drive <= cmd_close;
         open_drive <= cmd_open;
      end else if (running && (target_hit || cnt == '0)) begin
         close_drive <= 1'b0;
         open_drive <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         ev_done <= 1'b0;
         ev_fault <= 1'b0;
      end else begin
         ev_done <= running & ~new_cmd & target_hit;
         ev_fault <= expire;
      end
   end

   // failed transition kept for single contact
   always_ff @(posedge clock) begin
      if (rst) begin
         failed <= 1'b0;
      end else if (new_cmd) begin
         failed <= 1'b0;
      end else if (expire) begin
         failed <= 1'b1;
      end
   end

   always_comb begin
      next_pos = POS_FAULT;
      if (force_open) begin
         next_pos = POS_OPEN;
      end else if (no_contact) begin
         next_pos = POS_FAULT;
      end else if (new_cmd && !(cmd_close ? at_closed : at_open)) begin
         // fresh command shows transit in step with its coil
         next_pos = POS_TRANSIT;
      end else if (running && !target_hit) begin
         next_pos = POS_TRANSIT;
      end else if (single && failed) begin
         next_pos = POS_FAULT;
      end else if (at_closed) begin
         next_pos = POS_CLOSED;
      end else if (at_open) begin
         next_pos = POS_OPEN;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         pos <= POS_FAULT;
      end else begin
         pos <= next_pos;
      end
   end
endmodule
